// ---- rtl/copper_link_extended_status.sv ----
// copper link extended status register with sticky event flags
//
// Contract
// - register answers at device address 7, offset 0xFFF1
// - bit 15 latches selector mismatch, clears on read
// - bit 14 reads 1 while advertised speed is downgraded, else 0
// - bit 13 reads 1 in crossover pair mode, else 0
// - bit 11 remote ok; not-ok latches 0 until read while ok
// - bit 10 local ok; not-ok latches 0 until read while ok
// - bit 9 shows live descrambler lock
// - bit 8 shows live link pass
// - bit 7 reports a CRC error since previous read
// - bit 6 latches carrier extension error, clears on read
// - bit 5 latches bad start delimiter, clears on read
// - bit 4 latches bad end delimiter, clears on read
// - bit 3 latches invalid code packet, clears on read
// - bit 2 latches transmit error code packet, clears on read
// - bit 1 latches descrambler loss of lock, clears on read
// - bit 0 latches three-level code error, clears on read
`timescale 1ns/1ps
`include "copper_status_defs.svh"
module copper_link_extended_status (
   input  wire logic                       clock,
   input  wire logic                       srst,
   input  wire copper_status_pkg::mgmt_req_s   mgmt_req,
   input  wire copper_status_pkg::phy_events_s events,
   input  wire copper_status_pkg::phy_levels_s levels,
   output copper_status_pkg::mgmt_resp_s   mgmt_resp
);
   import copper_status_pkg::*;

   status_state_s           state;
   status_state_s           next_state;
   logic                    hit;
   logic                    rd;
   logic                    wr;
   logic                    mismatch_evt;
   logic                    lock_loss_evt;
   logic [`LH_COUNT-1:0]    hi_event;
   logic [`LH_COUNT-1:0]    hi_flag;
   logic [`LL_COUNT-1:0]    lo_ok;
   logic [`LL_COUNT-1:0]    lo_view;
   logic [`STAT_W-1:0]      status_now;

   // ==========================================================
   // address decode
   // decode device and offset
   always_comb begin
      hit = 1'b0;
      if (mgmt_req.valid && mgmt_req.management_device_address == `STATUS_MANAGEMENT_DEVICE_ADDRESS
          && mgmt_req.addr == `STATUS_OFFSET) begin
         hit = 1'b1;
      end
   end

   assign rd = hit & ~mgmt_req.write;
   assign wr = hit & mgmt_req.write;

   // ==========================================================
   // event detection
   // selector mismatch on page arrival
   assign mismatch_evt = events.base_page_rx
                       & (events.partner_selector
                          != events.advertised_selector);
   assign lock_loss_evt = state.locked & ~levels.descrambler_locked;

   always_comb begin
      hi_event               = '0;
      hi_event[`LH_MISMATCH] = mismatch_evt;
      hi_event[`BIT_CRC]         = events.crc_error;
      hi_event[`BIT_CARRIER_EXT] = events.carrier_ext_error;
      hi_event[`BIT_BAD_SSD]     = events.bad_ssd;
      hi_event[`BIT_BAD_ESD]     = events.bad_esd;
      hi_event[`BIT_RX_CODE]     = events.invalid_code;
      hi_event[`BIT_TX_CODE]     = events.tx_error_code;
      hi_event[`BIT_LOCK_ERR]    = lock_loss_evt;
      hi_event[`BIT_MLT3]    = events.mlt3_error;
   end

   assign lo_ok[`LL_REMOTE] = levels.remote_rx_ok;
   assign lo_ok[`LL_LOCAL]  = levels.local_rx_ok;

   // ==========================================================
   // sticky flags, cleared by the same read that captures them
   latch_status_bank u_latches (
      .clock      (clock),
      .srst       (srst),
      .read_clear (rd),
      .hi_event   (hi_event),
      .lo_ok      (lo_ok),
      .hi_flag    (hi_flag),
      .lo_view    (lo_view)
   );

   // ==========================================================
   // status word
   always_comb begin
      status_now                     = `STAT_RESET;
      status_now[`BIT_SEL_MISMATCH]  = hi_flag[`LH_MISMATCH];
      status_now[`BIT_DOWNGRADE]     = state.downgrade;
      status_now[`BIT_CROSSOVER]     = state.crossover;
      // reserved bit reads back what was written
      status_now[`BIT_RESERVED]      = state.reserved;
      status_now[`BIT_REMOTE_RX]     = lo_view[`LL_REMOTE];
      status_now[`BIT_LOCAL_RX]      = lo_view[`LL_LOCAL];
      status_now[`BIT_LOCKED]        = state.locked;
      status_now[`BIT_LINK]          = state.link;
      status_now[`LH_LOW_TOP:0]      = hi_flag[`LH_LOW_TOP:0];
   end

   // ==========================================================
   // state update
   always_comb begin
      next_state            = state;
      next_state.downgrade  = levels.speed_downgraded;
      next_state.crossover  = levels.crossover;
      next_state.locked     = levels.descrambler_locked;
      next_state.link       = levels.link_pass;
      next_state.resp.valid = rd;
      if (rd) begin
         next_state.resp.data = status_now;
      end
      // writes touch only the reserved storage; status bits are read-only
      if (wr) begin
         next_state.reserved = mgmt_req.wdata[`BIT_RESERVED];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign mgmt_resp = state.resp;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   read_answer_a: assert property (
      rd |=> mgmt_resp.valid)
      else $error("status read not answered next cycle");

   foreign_silent_a: assert property (
      !rd |=> !mgmt_resp.valid)
      else $error("answer without a matching read");

   mismatch_latch_a: assert property (
      mismatch_evt ##1 rd |=> mgmt_resp.data[`BIT_SEL_MISMATCH])
      else $error("selector mismatch not reported");

   crossover_view_a: assert property (
      rd |=> mgmt_resp.data[`BIT_CROSSOVER] == $past(levels.crossover, 2))
      else $error("crossover bit does not follow pair state");

   downgrade_view_a: assert property (
      rd |=> mgmt_resp.data[`BIT_DOWNGRADE]
             == $past(levels.speed_downgraded, 2))
      else $error("downgrade bit wrong");

   lock_live_a: assert property (
      rd |=> mgmt_resp.data[`BIT_LOCKED]
             == $past(levels.descrambler_locked, 2))
      else $error("lock bit not live");

   link_live_a: assert property (
      rd |=> mgmt_resp.data[`BIT_LINK] == $past(levels.link_pass, 2))
      else $error("link bit not live");

   flags_cleared_a: assert property (
      (rd && hi_event == '0) ##1 (rd && hi_event == '0)
      |=> (mgmt_resp.data & `LH_MASK) == `STAT_RESET)
      else $error("sticky flags survived a clearing read");

   crc_same_cycle_a: assert property (
      rd && events.crc_error |=> hi_flag[`BIT_CRC])
      else $error("event lost in clearing read cycle");

   local_low_hold_a: assert property (
      !levels.local_rx_ok |=> !status_now[`BIT_LOCAL_RX])
      else $error("local receiver drop not latched");

   remote_low_hold_a: assert property (
      !levels.remote_rx_ok ##1 (!rd && levels.remote_rx_ok)
      |=> !status_now[`BIT_REMOTE_RX])
      else $error("remote receiver low released without read");

   lock_loss_flag_a: assert property (
      lock_loss_evt |=> status_now[`BIT_LOCK_ERR])
      else $error("loss of lock not latched");

   reset_zero_a: assert property (
      @(posedge clock) disable iff (1'b0)
      srst |=> hi_flag == `LH_RESET && !mgmt_resp.valid
               && !state.link && !state.locked)
      else $error("status not clear after reset");

   read_flag_c: cover property (
      events.bad_ssd ##1 rd ##1 mgmt_resp.data[`BIT_BAD_SSD]);
   low_release_c: cover property (
      !levels.local_rx_ok ##1 levels.local_rx_ok ##1 rd
      ##1 status_now[`BIT_LOCAL_RX]);
   reserved_write_c: cover property (wr ##1 rd);
   lock_loss_c: cover property (lock_loss_evt ##1 rd);

endmodule // copper_link_extended_status

// ---- rtl/copper_status_defs.svh ----
// constants for the copper link extended status register
`ifndef COPPER_STATUS_DEFS_SVH
`define COPPER_STATUS_DEFS_SVH

// ==========================================================
// addressing
`define MGMT_MANAGEMENT_DEVICE_ADDRESS_W        5
`define MGMT_ADDR_W         16
`define STAT_W              16
`define STATUS_MANAGEMENT_DEVICE_ADDRESS        5'h07
`define STATUS_OFFSET       16'hFFF1
`define SELECTOR_W          5

// ==========================================================
// bit positions
`define BIT_SEL_MISMATCH    15
`define BIT_DOWNGRADE       14
`define BIT_CROSSOVER       13
`define BIT_RESERVED        12
`define BIT_REMOTE_RX       11
`define BIT_LOCAL_RX        10
`define BIT_LOCKED          9
`define BIT_LINK            8
`define BIT_CRC             7
`define BIT_CARRIER_EXT     6
`define BIT_BAD_SSD         5
`define BIT_BAD_ESD         4
`define BIT_RX_CODE         3
`define BIT_TX_CODE         2
`define BIT_LOCK_ERR        1
`define BIT_MLT3            0

// ==========================================================
// latch banks: high flag i sits on status bit i, last one on bit 15
`define LH_COUNT            9
`define LL_COUNT            2
`define LH_MISMATCH         8
`define LH_LOW_TOP          7
`define LL_REMOTE           1
`define LL_LOCAL            0
`define LH_MASK             16'h80FF

// ==========================================================
// reset values
`define STAT_RESET          16'h0000
`define LH_RESET            9'h000
`define LL_RESET            2'h0

`endif

// ---- rtl/copper_status_pkg.sv ----
// types shared by the copper link extended status logic
package copper_status_pkg;
`include "copper_status_defs.svh"

   // ==========================================================
   // management access
   typedef struct packed {
      logic                       valid;
      logic                       write;
      logic [`MGMT_MANAGEMENT_DEVICE_ADDRESS_W-1:0]   management_device_address;
      logic [`MGMT_ADDR_W-1:0]    addr;
      logic [`STAT_W-1:0]         wdata;
   } mgmt_req_s;

   typedef struct packed {
      logic                       valid;
      logic [`STAT_W-1:0]         data;
   } mgmt_resp_s;

   // ==========================================================
   // receive path detectors
   typedef struct packed {
      logic                       base_page_rx;
      logic [`SELECTOR_W-1:0]     partner_selector;
      logic [`SELECTOR_W-1:0]     advertised_selector;
      logic                       crc_error;
      logic                       carrier_ext_error;
      logic                       bad_ssd;
      logic                       bad_esd;
      logic                       invalid_code;
      logic                       tx_error_code;
      logic                       mlt3_error;
   } phy_events_s;

   typedef struct packed {
      logic                       speed_downgraded;
      logic                       crossover;
      logic                       remote_rx_ok;
      logic                       local_rx_ok;
      logic                       descrambler_locked;
      logic                       link_pass;
   } phy_levels_s;

   // ==========================================================
   // state
   typedef struct packed {
      logic [`LH_COUNT-1:0]       hi;
      logic [`LL_COUNT-1:0]       lo_held;
   } latch_bank_s;

   typedef struct packed {
      mgmt_resp_s                 resp;
      logic                       downgrade;
      logic                       crossover;
      logic                       locked;
      logic                       link;
      logic                       reserved;
   } status_state_s;

endpackage

// ---- rtl/latch_status_bank.sv ----
// sticky high and low latches cleared by a status read
`timescale 1ns/1ps
`include "copper_status_defs.svh"
module latch_status_bank (
   input  wire logic                 clock,
   input  wire logic                 srst,
   input  wire logic                 read_clear,
   input  wire logic [`LH_COUNT-1:0] hi_event,
   input  wire logic [`LL_COUNT-1:0] lo_ok,
   output logic      [`LH_COUNT-1:0] hi_flag,
   output logic      [`LL_COUNT-1:0] lo_view
);
   import copper_status_pkg::*;

   latch_bank_s             state;
   latch_bank_s             next_state;
   logic [`LH_COUNT-1:0]    next_hi;
   logic [`LL_COUNT-1:0]    next_lo;

   // ==========================================================
   // per bit next values
   genvar i;
   generate
      for (i = 0; i < `LH_COUNT; i = i + 1) begin : g_hi
         assign next_hi[i] = hi_event[i] | (state.hi[i] & ~read_clear);
      end
      for (i = 0; i < `LL_COUNT; i = i + 1) begin : g_lo
         // hold low until read sees ok
         assign next_lo[i] = ~lo_ok[i]
                           | (state.lo_held[i] & ~(read_clear & lo_ok[i]));
         assign lo_view[i] = lo_ok[i] & ~state.lo_held[i];
      end
   endgenerate

   assign hi_flag = state.hi;

   // ==========================================================
   // state register
   always_comb begin
      next_state         = state;
      next_state.hi      = next_hi;
      next_state.lo_held = next_lo;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state <= '{hi: `LH_RESET, lo_held: `LL_RESET};
      end else begin
         state <= next_state;
      end
   end

endmodule // latch_status_bank

// ---- bench/mgmt_host_model.sv ----
// management host model issuing single register accesses
`timescale 1ns/1ps
`include "copper_status_defs.svh"
module mgmt_host_model (
   input  wire logic                    clock,
   output copper_status_pkg::mgmt_req_s mgmt_req
);
   import copper_status_pkg::*;

   initial begin
      mgmt_req = '0;
   end

   // ==========================================================
   // one access
   // strobe lasts a single cycle; released fields show the inverse
   // of the last value so a stale address can never hit by luck
   task automatic access(input logic                     wr,
                         input logic [`MGMT_MANAGEMENT_DEVICE_ADDRESS_W-1:0] dv,
                         input logic [`MGMT_ADDR_W-1:0]  ad,
                         input logic [`STAT_W-1:0]       wd);
      @(negedge clock);
      mgmt_req.valid = 1'b1;
      mgmt_req.write = wr;
      mgmt_req.management_device_address = dv;
      mgmt_req.addr  = ad;
      mgmt_req.wdata = wd;
      @(negedge clock);
      mgmt_req.valid = 1'b0;
      mgmt_req.write = ~wr;
      mgmt_req.management_device_address = ~dv;
      mgmt_req.addr  = ~ad;
      mgmt_req.wdata = ~wd;
   endtask
endmodule // mgmt_host_model

// ---- bench/copper_link_extended_status_tb_top.sv ----
// self-checking bench for the copper link extended status register
`timescale 1ns/1ps
`include "copper_status_defs.svh"
module copper_link_extended_status_tb_top;
   import copper_status_pkg::*;
   logic              clock;
   logic              srst;
   mgmt_req_s         mgmt_req;
   phy_events_s       events;
   phy_levels_s       levels;
   mgmt_resp_s        mgmt_resp;
   logic [15:0]       exp_q[$];
   logic [15:0]       bitv;
   int                n_fail;
   int                n_checks;

   copper_link_extended_status dut (
      .clock     (clock),
      .srst      (srst),
      .mgmt_req  (mgmt_req),
      .events    (events),
      .levels    (levels),
      .mgmt_resp (mgmt_resp)
   );

   mgmt_host_model host (
      .clock    (clock),
      .mgmt_req (mgmt_req)
   );

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // ==========================================================
   // verdict and compare
   task automatic conclude();
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // an answer with nothing pending is an error too
   always @(negedge clock) begin
      if (mgmt_resp.valid !== 1'b0) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=none", $time, mgmt_resp.data);
         end else begin
            check(mgmt_resp.data, exp_q.pop_front());
         end
      end
   end

   // ==========================================================
   // stimulus helpers
   task automatic rd(input logic [15:0] e);
      exp_q.push_back(e);
      host.access(1'b0, `STATUS_MANAGEMENT_DEVICE_ADDRESS, `STATUS_OFFSET, 16'h0000);
   endtask

   task automatic setlv(input logic [5:0] v);
      @(negedge clock);
      levels = v;
      repeat (2) @(negedge clock);
   endtask

   // low seven event bits run crc error down to three-level error
   task automatic pulse(input int j);
      @(negedge clock);
      events[j] = 1'b1;
      @(negedge clock);
      events[6:0] = 7'h00;
   endtask

   task automatic page(input logic [4:0] flip);
      @(negedge clock);
      events.advertised_selector = 5'($urandom);
      events.partner_selector = events.advertised_selector ^ flip;
      events.base_page_rx = 1'b1;
      @(negedge clock);
      events.base_page_rx = 1'b0;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h63946354));
      n_fail = 0;
      n_checks = 0;
      srst = 1'b1;
      events = '0;
      levels = '0;
      repeat (5) @(negedge clock);
      srst = 1'b0;
      rd(16'h0000);
      setlv(6'h3F);
      // receivers were not ok through reset: first read still shows them low
      rd(16'h6300);
      setlv(6'h0C);
      rd(16'h0C02);
      rd(16'h0C00);
      setlv(6'h3F);
      rd(16'h6F00);
      for (int j = 0; j < 7; j++) begin
         bitv = (j == 0) ? 16'h0001 : 16'h0001 << (j + 1);
         pulse(j);
         rd(16'h6F00 | bitv);
         rd(16'h6F00);
      end
      page(5'h00);
      rd(16'h6F00);
      page(5'($urandom_range(31, 1)));
      rd(16'hEF00);
      rd(16'h6F00);
      fork
         pulse(3);
         rd(16'h6F00);
      join
      rd(16'h6F10);
      setlv(6'h37);
      rd(16'h6700);
      setlv(6'h3F);
      rd(16'h6700);
      rd(16'h6F00);
      setlv(6'h3B);
      setlv(6'h3F);
      rd(16'h6B00);
      rd(16'h6F00);
      host.access(1'b1, `STATUS_MANAGEMENT_DEVICE_ADDRESS, `STATUS_OFFSET, 16'h7F00);
      rd(16'h7F00);
      host.access(1'b1, `STATUS_MANAGEMENT_DEVICE_ADDRESS, `STATUS_OFFSET, 16'h6F00);
      rd(16'h6F00);
      host.access(1'b0, 5'($urandom_range(6, 0)), `STATUS_OFFSET,
                  16'h0000);
      host.access(1'b1, `STATUS_MANAGEMENT_DEVICE_ADDRESS, 16'($urandom_range(16'hFFF0)),
                  16'h7F00);
      rd(16'h6F00);
      repeat (4) @(negedge clock);
      if (exp_q.size() != 0) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, 0, exp_q.size());
      end
      conclude();
   end

   // hang guard, well above the roughly 120 cycles the run needs
   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      conclude();
   end
endmodule // copper_link_extended_status_tb_top
